// ===== logic/awc_cfg.svh
// Purpose: Constants for the always-on LIN wakeup configuration bank
// Assumes: Included by the package and by the bank module
// Notes:   Offsets are byte addresses on the register bus
`ifndef AWC_CFG_SVH
`define AWC_CFG_SVH

// Bus shape
`define AWC_ADDR_W          32
`define AWC_DATA_W          32
`define AWC_STRB_W          4
`define AWC_RESP_OKAY       2'h0
`define AWC_RESP_SLVERR     2'h2

// Register offsets
`define AWC_OFS_SCRATCH     32'h50015000
`define AWC_OFS_GATE        32'h50015004
`define AWC_OFS_FILTER      32'h50015008
`define AWC_OFS_WAKEUP      32'h5001500C
`define AWC_OFS_PIN         32'h50015010
`define AWC_OFS_UPDATE      32'h50015014

// Access gate fields
`define AWC_GATE_LOCK_BIT   31
`define AWC_GATE_STAT_BIT   4
`define AWC_ACCESS_KEY      4'hB

// Filter fields
`define AWC_FLT_RISE_LSB    12
`define AWC_FLT_FALL_LSB    8
`define AWC_FLT_HRST_BIT    0
`define AWC_RISE_THR_RST    4'h0
`define AWC_FALL_THR_RST    4'h1

// Wakeup control fields
`define AWC_WUP_FLAG_BIT    11
`define AWC_WUP_RLS_BIT     10
`define AWC_WUP_IDLE_LSB    8
`define AWC_WUP_THR_LSB     2
`define AWC_WUP_THR_RST     6'h24
`define AWC_IDLE_SEL_RST    2'h0

// Pin control fields
`define AWC_PIN_TP_LSB      24
`define AWC_PIN_SLEW_LSB    16
`define AWC_PIN_DUTY_LSB    13
`define AWC_PIN_BIAS_LSB    10
`define AWC_PIN_RXDLY_LSB   8
`define AWC_PIN_PUOFF_BIT   6
`define AWC_PIN_RXEN_BIT    1
`define AWC_PIN_PUEN_BIT    0
`define AWC_TP_SEL_RST      4'h0
`define AWC_SLEW_RST        4'h4
`define AWC_DUTY_RST        3'h5
`define AWC_BIAS_RST        3'h4
`define AWC_RXDLY_RST       2'h0

// Update strobe field
`define AWC_UPD_BIT         0

// Timing: dominant timeout, least figure of its window
`define AWC_DOM_TIMEOUT_MS  4000
`define AWC_CLK_MHZ         250

// Idle limits in prescaled slow clock ticks, one per selection
`define AWC_IDLE_TICKS_0    24'h0F4240
`define AWC_IDLE_TICKS_1    24'h16E360
`define AWC_IDLE_TICKS_2    24'h1E8480
`define AWC_IDLE_TICKS_3    24'h2625A0

`endif

// ===== logic/awc_pkg.sv
// Purpose: Types for the always-on LIN wakeup configuration bank
// Assumes: awc_cfg.svh supplies widths
// Notes:   Bus request and answer travel as packed structs
`default_nettype none
`include "awc_cfg.svh"

package awc_pkg;

  // Register bus request from the master
  typedef struct packed {
    logic                     awvalid;
    logic [`AWC_ADDR_W-1:0]   awaddr;
    logic                     wvalid;
    logic [`AWC_DATA_W-1:0]   wdata;
    logic [`AWC_STRB_W-1:0]   wstrb;
    logic                     bready;
    logic                     arvalid;
    logic [`AWC_ADDR_W-1:0]   araddr;
    logic                     rready;
  } awc_axil_req_t;

  // Register bus answer to the master
  typedef struct packed {
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [`AWC_DATA_W-1:0]   rdata;
    logic [1:0]               rresp;
  } awc_axil_rsp_t;

  // Whole state of the bank
  typedef struct packed {
    awc_axil_rsp_t            rsp;
    logic                     aw_held;
    logic                     w_held;
    logic [`AWC_ADDR_W-1:0]   waddr;
    logic [`AWC_DATA_W-1:0]   wdata;
    logic [`AWC_STRB_W-1:0]   wstrb;
    logic [7:0]               scratch;
    logic                     lock;
    logic [3:0]               key;
    logic                     access;
    logic [3:0]               rise_thr;
    logic [3:0]               fall_thr;
    logic                     hrst_en;
    logic                     rls_wup_en;
    logic [1:0]               idle_sel;
    logic [5:0]               wup_thr;
    logic [1:0]               idle_sel_act;
    logic [5:0]               wup_thr_act;
    logic [3:0]               tp_sel;
    logic [3:0]               slew;
    logic [2:0]               duty;
    logic [2:0]               bias;
    logic [1:0]               rxdly;
    logic                     puoff;
    logic                     rx_en;
    logic                     pu_en;
    logic                     rx_f;
    logic [3:0]               flt_cnt;
    logic                     flag;
    logic [29:0]              dom_cnt;
    logic [6:0]               wup_cnt;
    logic [23:0]              idle_cnt;
    logic                     idle;
    logic                     wakeup;
    logic                     pu_on;
    logic [3:0]               tp_route;
  } awc_state_t;

endpackage : awc_pkg
`default_nettype wire

// ===== logic/awc_bank.sv
// Purpose: Always-on LIN slave wakeup and pin configuration bank
// Assumes: AXI4-Lite slave; bus line, slow clock ticks synchronous to aclk
// Notes:   por_n resets only the retained fields; aresetn spares retained fields
`timescale 1ns/10ps
`default_nettype none
`include "awc_cfg.svh"

// Functional notes
// - Eight-bit scratch byte cleared only by power-on reset, kept through other resets.
// - Writing key 0xB enables protected access; any other key value disables it.
// - Status bit 4 of the gate reads one while protected access is enabled.
// - Lock bit is set-only; once set the key field can no longer change.
// - Filter, wakeup and pin writes take effect only while protected access is enabled.
// - Filter accepts rise after high persists rise-threshold slow ticks; resets to zero.
// - Filter accepts fall after low persists fall-threshold slow ticks; resets to one.
// - With its enable set, a high bus line resets the filter at once.
// - In hardware mode, long dominant bus sets stuck flag; any transition clears it.
// - While the stuck flag and the cut-off enable are both set, the bus pull-up is switched off.
// - Cut-off enable resets to one, only by power-on; pull-up returns with activity.
// - With release wakeup enabled, dominant release after stuck flag raises wakeup.
// - Wakeup when dominant pulse exceeds six-bit threshold prescaled ticks; resets to 0x24.
// - Without core hibernate keep, threshold and inactivity apply only after update strobe.
// - Two-bit inactivity selection, reset zero, sets the idle detection period.
// - Receive enable resets to zero, pull-up enable resets to one.
// - One-hot four-bit test point select routes one transmitter point; resets zero.
// - Four-bit slew select resets to 0x4; all ones selects fast slew.
// - Three-bit duty adjust resets to 0x5, nominal fifty percent.
// - Pull-down bias resets to 0x4; receive delay select resets to zero.
module awc_bank
  import awc_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT_CYCLES = `AWC_DOM_TIMEOUT_MS * 1000 * `AWC_CLK_MHZ
) (
  // Clock, resets, enable
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          por_n,
  input  wire logic          ce,
  // Register bus
  input  wire awc_axil_req_t axil_req,
  output var  awc_axil_rsp_t axil_rsp,
  // Bus line and slow clock ticks
  input  wire logic          rxd_raw,
  input  wire logic          lf_tick,
  input  wire logic          presc_tick,
  input  wire logic          lin_hw_mode,
  input  wire logic          core_domain_hibernate_keep,
  // Transceiver controls and status
  output logic               bus_pullup_on,
  output logic               bus_receive_enable,
  output logic [3:0]         tx_testpoint_route,
  output logic [3:0]         tx_slew_select,
  output logic [2:0]         tx_duty_adjust,
  output logic [2:0]         tx_pulldown_bias,
  output logic [1:0]         rx_delay_select,
  output logic               rx_filtered,
  output logic               dominant_stuck_flag,
  output logic               bus_wakeup,
  output logic               bus_idle,
  output logic               cfg_access_enabled
);

  awc_state_t              st;
  awc_state_t              next_st;
  logic [`AWC_DATA_W-1:0]  wmask;

  // Byte enables widened to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < `AWC_STRB_W; gb++) begin : g_mask
      assign wmask[gb*8 +: 8] = {8{st.wstrb[gb]}};
    end
  endgenerate

  // Register read view
  function automatic logic [`AWC_DATA_W-1:0] read_word(input awc_state_t s,
                                                        input logic [`AWC_ADDR_W-1:0] a);
    logic [`AWC_DATA_W-1:0] d;
    d = '0;
    case (a)
      `AWC_OFS_SCRATCH: d[7:0] = s.scratch;
      `AWC_OFS_GATE: begin
        d[`AWC_GATE_LOCK_BIT]  = s.lock;
        d[`AWC_GATE_STAT_BIT]  = (s.key == `AWC_ACCESS_KEY);
        d[3:0]                 = s.key;
      end
      `AWC_OFS_FILTER: begin
        d[`AWC_FLT_RISE_LSB +: 4] = s.rise_thr;
        d[`AWC_FLT_FALL_LSB +: 4] = s.fall_thr;
        d[`AWC_FLT_HRST_BIT]      = s.hrst_en;
      end
      `AWC_OFS_WAKEUP: begin
        d[`AWC_WUP_FLAG_BIT]      = s.flag;
        d[`AWC_WUP_RLS_BIT]       = s.rls_wup_en;
        d[`AWC_WUP_IDLE_LSB +: 2] = s.idle_sel;
        d[`AWC_WUP_THR_LSB +: 6]  = s.wup_thr;
      end
      `AWC_OFS_PIN: begin
        d[`AWC_PIN_TP_LSB +: 4]    = s.tp_sel;
        d[`AWC_PIN_SLEW_LSB +: 4]  = s.slew;
        d[`AWC_PIN_DUTY_LSB +: 3]  = s.duty;
        d[`AWC_PIN_BIAS_LSB +: 3]  = s.bias;
        d[`AWC_PIN_RXDLY_LSB +: 2] = s.rxdly;
        d[`AWC_PIN_PUOFF_BIT]      = s.puoff;
        d[`AWC_PIN_RXEN_BIT]       = s.rx_en;
        d[`AWC_PIN_PUEN_BIT]       = s.pu_en;
      end
      default: d = '0;
    endcase
    return d;
  endfunction : read_word

  // Address is one of the mapped words
  function automatic logic mapped(input logic [`AWC_ADDR_W-1:0] a);
    return (a == `AWC_OFS_SCRATCH) || (a == `AWC_OFS_GATE) || (a == `AWC_OFS_FILTER) ||
           (a == `AWC_OFS_WAKEUP) || (a == `AWC_OFS_PIN) || (a == `AWC_OFS_UPDATE);
  endfunction : mapped

  // Idle limit for a selection
  function automatic logic [23:0] idle_limit(input logic [1:0] sel);
    logic [23:0] lim;
    case (sel)
      2'h0:    lim = `AWC_IDLE_TICKS_0;
      2'h1:    lim = `AWC_IDLE_TICKS_1;
      2'h2:    lim = `AWC_IDLE_TICKS_2;
      default: lim = `AWC_IDLE_TICKS_3;
    endcase
    return lim;
  endfunction : idle_limit

  // Next state of the whole bank
  always_comb begin
    logic [`AWC_DATA_W-1:0] merged;
    logic                   access_en;
    logic [3:0]             thr;
    logic                   rise;
    logic                   edge_seen;
    merged    = '0;
    access_en = (st.key == `AWC_ACCESS_KEY);
    thr       = '0;
    rise      = 1'b0;
    edge_seen = 1'b0;
    next_st   = st;
    if (ce && aresetn) begin
      // Write address and data channels, taken in either order
      if (axil_req.awvalid && st.rsp.awready) begin
        next_st.aw_held = 1'b1;
        next_st.waddr   = axil_req.awaddr;
      end
      if (axil_req.wvalid && st.rsp.wready) begin
        next_st.w_held = 1'b1;
        next_st.wdata  = axil_req.wdata;
        next_st.wstrb  = axil_req.wstrb;
      end
      if (st.rsp.bvalid && axil_req.bready) begin
        next_st.rsp.bvalid = 1'b0;
      end
      // Perform the write once both halves are held
      if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
        merged = (read_word(st, st.waddr) & ~wmask) | (st.wdata & wmask);
        next_st.aw_held   = 1'b0;
        next_st.w_held    = 1'b0;
        next_st.rsp.bvalid = 1'b1;
        next_st.rsp.bresp  = mapped(st.waddr) ? `AWC_RESP_OKAY : `AWC_RESP_SLVERR;
        case (st.waddr)
          `AWC_OFS_SCRATCH: next_st.scratch = merged[7:0];
          `AWC_OFS_GATE: begin
            if (!st.lock) begin
              next_st.key = merged[3:0];
            end
            next_st.lock = st.lock | merged[`AWC_GATE_LOCK_BIT];
          end
          `AWC_OFS_FILTER: begin
            if (access_en) begin
              next_st.rise_thr = merged[`AWC_FLT_RISE_LSB +: 4];
              next_st.fall_thr = merged[`AWC_FLT_FALL_LSB +: 4];
              next_st.hrst_en  = merged[`AWC_FLT_HRST_BIT];
            end
          end
          `AWC_OFS_WAKEUP: begin
            if (access_en) begin
              next_st.rls_wup_en = merged[`AWC_WUP_RLS_BIT];
              next_st.idle_sel   = merged[`AWC_WUP_IDLE_LSB +: 2];
              next_st.wup_thr    = merged[`AWC_WUP_THR_LSB +: 6];
            end
          end
          `AWC_OFS_PIN: begin
            if (access_en) begin
              next_st.tp_sel = merged[`AWC_PIN_TP_LSB +: 4];
              next_st.slew   = merged[`AWC_PIN_SLEW_LSB +: 4];
              next_st.duty   = merged[`AWC_PIN_DUTY_LSB +: 3];
              next_st.bias   = merged[`AWC_PIN_BIAS_LSB +: 3];
              next_st.rxdly  = merged[`AWC_PIN_RXDLY_LSB +: 2];
              next_st.puoff  = merged[`AWC_PIN_PUOFF_BIT];
              next_st.rx_en  = merged[`AWC_PIN_RXEN_BIT];
              next_st.pu_en  = merged[`AWC_PIN_PUEN_BIT];
            end
          end
          `AWC_OFS_UPDATE: begin
            if (merged[`AWC_UPD_BIT] && !core_domain_hibernate_keep) begin
              next_st.wup_thr_act  = st.wup_thr;
              next_st.idle_sel_act = st.idle_sel;
            end
          end
          default: next_st.rsp.bresp = `AWC_RESP_SLVERR;
        endcase
      end
      // With the core kept alive, settings apply directly
      if (core_domain_hibernate_keep) begin
        next_st.wup_thr_act  = next_st.wup_thr;
        next_st.idle_sel_act = next_st.idle_sel;
      end
      // Read channel
      if (st.rsp.rvalid && axil_req.rready) begin
        next_st.rsp.rvalid = 1'b0;
      end
      if (axil_req.arvalid && st.rsp.arready) begin
        next_st.rsp.rvalid = 1'b1;
        next_st.rsp.rdata  = read_word(st, axil_req.araddr);
        next_st.rsp.rresp  = mapped(axil_req.araddr) ? `AWC_RESP_OKAY : `AWC_RESP_SLVERR;
      end
      next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
      next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;
      next_st.rsp.arready = !next_st.rsp.rvalid;

      // Sleep-mode glitch filter on the received line
      if (st.hrst_en && rxd_raw) begin
        next_st.rx_f    = 1'b1;
        next_st.flt_cnt = '0;
      end else if (lf_tick) begin
        if (rxd_raw != st.rx_f) begin
          thr = rxd_raw ? st.rise_thr : st.fall_thr;
          if (st.flt_cnt >= thr) begin
            next_st.rx_f    = rxd_raw;
            next_st.flt_cnt = '0;
          end else begin
            next_st.flt_cnt = st.flt_cnt + 4'h1;
          end
        end else begin
          next_st.flt_cnt = '0;
        end
      end
      rise      = next_st.rx_f && !st.rx_f;
      edge_seen = next_st.rx_f != st.rx_f;

      // Dominant stuck detection
      next_st.wakeup = 1'b0;
      if (edge_seen) begin
        next_st.flag    = 1'b0;
        next_st.dom_cnt = '0;
        if (rise && st.flag && st.rls_wup_en) begin
          next_st.wakeup = 1'b1;
        end
      end else if (st.rx_f || !lin_hw_mode) begin
        next_st.dom_cnt = '0;
      end else if (!st.flag) begin
        if (st.dom_cnt == 30'(DOM_TIMEOUT_CYCLES - 1)) begin
          next_st.flag = 1'b1;
        end else begin
          next_st.dom_cnt = st.dom_cnt + 30'h1;
        end
      end

      // Wakeup pulse width measured in prescaled ticks
      if (rise) begin
        if (st.wup_cnt > {1'b0, st.wup_thr_act}) begin
          next_st.wakeup = 1'b1;
        end
        next_st.wup_cnt = '0;
      end else if (!st.rx_f && presc_tick && st.wup_cnt != 7'h7F) begin
        next_st.wup_cnt = st.wup_cnt + 7'h1;
      end

      // Bus inactivity detection
      if (!next_st.rx_f) begin
        next_st.idle_cnt = '0;
        next_st.idle     = 1'b0;
      end else if (presc_tick && !st.idle) begin
        if (st.idle_cnt + 24'h1 >= idle_limit(st.idle_sel_act)) begin
          next_st.idle = 1'b1;
        end
        next_st.idle_cnt = st.idle_cnt + 24'h1;
      end

      // Registered transceiver controls
      next_st.pu_on    = next_st.pu_en && !(next_st.flag && next_st.puoff);
      next_st.tp_route = $onehot(next_st.tp_sel) ? next_st.tp_sel : 4'h0;
    end

    // Hard or soft reset spares retained fields
    if (!aresetn) begin
      next_st.rsp          = '0;
      next_st.aw_held      = 1'b0;
      next_st.w_held       = 1'b0;
      next_st.waddr        = '0;
      next_st.wdata        = '0;
      next_st.wstrb        = '0;
      next_st.rise_thr     = `AWC_RISE_THR_RST;
      next_st.fall_thr     = `AWC_FALL_THR_RST;
      next_st.hrst_en      = 1'b0;
      next_st.rls_wup_en   = 1'b0;
      next_st.idle_sel     = `AWC_IDLE_SEL_RST;
      next_st.wup_thr      = `AWC_WUP_THR_RST;
      next_st.idle_sel_act = `AWC_IDLE_SEL_RST;
      next_st.wup_thr_act  = `AWC_WUP_THR_RST;
      next_st.tp_sel       = `AWC_TP_SEL_RST;
      next_st.slew         = `AWC_SLEW_RST;
      next_st.duty         = `AWC_DUTY_RST;
      next_st.bias         = `AWC_BIAS_RST;
      next_st.rxdly        = `AWC_RXDLY_RST;
      next_st.rx_en        = 1'b0;
      next_st.pu_en        = 1'b1;
      next_st.rx_f         = 1'b1;
      next_st.flt_cnt      = '0;
      next_st.flag         = 1'b0;
      next_st.dom_cnt      = '0;
      next_st.wup_cnt      = '0;
      next_st.idle_cnt     = '0;
      next_st.idle         = 1'b0;
      next_st.wakeup       = 1'b0;
      next_st.pu_on        = 1'b1;
      next_st.tp_route     = 4'h0;
    end
    // Power-on resets only the retained fields: scratch, lock, key, cut-off enable
    if (!por_n) begin
      next_st.scratch      = 8'h00;
      next_st.lock         = 1'b0;
      next_st.key          = 4'h0;
      next_st.puoff        = 1'b1;
    end
    next_st.access         = (next_st.key == `AWC_ACCESS_KEY);
  end

  // State register
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // Outputs straight from state flops
  assign axil_rsp            = st.rsp;
  assign bus_pullup_on       = st.pu_on;
  assign bus_receive_enable  = st.rx_en;
  assign tx_testpoint_route  = st.tp_route;
  assign tx_slew_select      = st.slew;
  assign tx_duty_adjust      = st.duty;
  assign tx_pulldown_bias    = st.bias;
  assign rx_delay_select     = st.rxdly;
  assign rx_filtered         = st.rx_f;
  assign dominant_stuck_flag = st.flag;
  assign bus_wakeup          = st.wakeup;
  assign bus_idle            = st.idle;
  assign cfg_access_enabled  = st.access;

  // Scratch survives hard reset
  chk_scratch_kept: assert property (@(posedge aclk) disable iff (!por_n)
    !aresetn |=> $stable(st.scratch)) else $error("scratch lost on hard reset");

  // Lock never drops without power-on
  chk_lock_sticky: assert property (@(posedge aclk) disable iff (!por_n)
    st.lock |=> st.lock) else $error("lock cleared by software");

  // Key frozen under lock
  chk_key_frozen: assert property (@(posedge aclk) disable iff (!por_n)
    st.lock |=> $stable(st.key)) else $error("key changed while locked");

  // Filter writes dropped without the key
  chk_protect_gate: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (ce && st.aw_held && st.w_held && !st.rsp.bvalid && st.key != `AWC_ACCESS_KEY &&
     st.waddr == `AWC_OFS_FILTER) |=> $stable(st.rise_thr) && $stable(st.hrst_en))
    else $error("filter write applied while gated");

  // Fall accepted only after low persisted
  chk_fall_filter: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    $fell(st.rx_f) |-> $past(!rxd_raw && lf_tick && st.flt_cnt >= st.fall_thr))
    else $error("fall accepted early");

  // High line resets the filter
  chk_high_reset: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (ce && st.hrst_en && rxd_raw) |=> st.rx_f && st.flt_cnt == 4'h0)
    else $error("filter not reset by high line");

  // Stuck flag drops on a transition
  chk_flag_clear: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (st.flag && $changed(st.rx_f)) |-> !st.flag) else $error("flag kept after transition");

  // Pull-up cut while stuck
  chk_pullup_cut: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (ce && st.flag && st.puoff) ##1 (st.flag && st.puoff) |-> !bus_pullup_on)
    else $error("pull-up on while stuck");

  // Release after stuck raises a wakeup
  chk_release_wake: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (st.flag && st.rls_wup_en && $rose(st.rx_f)) or ($past(st.flag && st.rls_wup_en) &&
     $rose(st.rx_f)) |-> bus_wakeup) else $error("no wakeup on release");

  // Applied threshold waits for the strobe
  chk_update_hold: assert property (@(posedge aclk) disable iff (!por_n || !aresetn)
    (!core_domain_hibernate_keep && !(st.aw_held && st.w_held && st.waddr == `AWC_OFS_UPDATE))
    |=> $stable(st.wup_thr_act)) else $error("threshold applied without strobe");

endmodule : awc_bank
`default_nettype wire

// ===== bench/awc_line_model.sv
// Purpose: LIN bus line as the slave transceiver reports it
// Assumes: Slow clock ticks are derived from aclk
// Notes:   Line is pulled recessive unless dominant is asked for
`timescale 1ns/10ps
`default_nettype none
module awc_line_model (
  // Command in, line and ticks out
  input  wire logic aclk,
  input  wire logic dominant,
  output logic      rxd_raw,
  output logic      lf_tick,
  output logic      presc_tick
);
  logic [2:0] cnt   = 3'h0;
  logic       dom_q = 1'b0;
  // Tick counter and line state
  always @(posedge aclk) begin
    cnt   <= cnt + 3'h1;
    dom_q <= dominant;
  end
  // Ticks every 4 and 8 cycles; released line reads high
  assign lf_tick    = (cnt[1:0] == 2'h0);
  assign presc_tick = (cnt == 3'h0);
  assign rxd_raw    = !dom_q;
endmodule : awc_line_model
`default_nettype wire

// ===== bench/aon_lin_wakeup_config_tb.sv
// Purpose: Self-checking bench for the LIN wakeup configuration bank
// Assumes: Line model on the bus side; bank is an AXI4-Lite slave
// Notes:   Dominant timeout cut to 50 cycles
`timescale 1ns/10ps
`default_nettype none
module aon_lin_wakeup_config_tb
  import awc_pkg::*;
;
  // Row: write flag, offset, data written or expected, response
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] v; logic [1:0] r;} awc_row_t;
  localparam awc_row_t ROWS [23] = '{
    '{1'b0, 8'h00, 32'h0, 2'h0},
    '{1'b0, 8'h08, 32'h100, 2'h0},
    '{1'b0, 8'h0C, 32'h90, 2'h0},
    '{1'b0, 8'h10, 32'h4B041, 2'h0},
    '{1'b1, 8'h04, 32'hB, 2'h0},
    '{1'b0, 8'h04, 32'h1B, 2'h0},
    '{1'b1, 8'h04, 32'h7, 2'h0},
    '{1'b0, 8'h04, 32'h7, 2'h0},
    '{1'b1, 8'h08, 32'h1201, 2'h0},
    '{1'b0, 8'h08, 32'h100, 2'h0},
    '{1'b1, 8'h04, 32'hB, 2'h0},
    '{1'b1, 8'h08, 32'h1201, 2'h0},
    '{1'b0, 8'h08, 32'h1201, 2'h0},
    '{1'b1, 8'h10, 32'hFFFFFFFF, 2'h0},
    '{1'b0, 8'h10, 32'hF0FFF43, 2'h0},
    '{1'b1, 8'h0C, 32'hFFFFFFFF, 2'h0},
    '{1'b0, 8'h0C, 32'h7FC, 2'h0},
    '{1'b1, 8'h00, 32'hFFFFFFFF, 2'h0},
    '{1'b0, 8'h18, 32'h0, 2'h2},
    '{1'b1, 8'h14, 32'h1, 2'h0},
    '{1'b1, 8'h04, 32'h8000000B, 2'h0},
    '{1'b1, 8'h04, 32'h0, 2'h0},
    '{1'b0, 8'h04, 32'h8000001B, 2'h0}
  };
  logic          aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, dominant = 1'b0, hw = 1'b1, keep = 1'b1;
  logic          rxd_raw, lf_tick, presc_tick, bus_pullup_on, bus_receive_enable, rx_filtered;
  logic          dominant_stuck_flag, bus_wakeup, bus_idle, cfg_access_enabled;
  logic [3:0]    tx_testpoint_route, tx_slew_select;
  logic [2:0]    tx_duty_adjust, tx_pulldown_bias;
  logic [1:0]    rx_delay_select, rs;
  logic [31:0]   q;
  awc_axil_req_t req = '0;
  awc_axil_rsp_t rsp;
  int            error_cnt = 0, n_tests = 0, wup_n = 0;
  // Clock and wakeup pulse catcher
  always #2 aclk = ~aclk;
  always @(posedge aclk) if (bus_wakeup === 1'b1) wup_n <= wup_n + 1;
  // Far side and design
  awc_line_model u_awc_line_model (.aclk, .dominant, .rxd_raw, .lf_tick, .presc_tick);
  awc_bank #(.DOM_TIMEOUT_CYCLES(50)) u_awc_bank (.aclk, .aresetn, .por_n, .ce(1'b1), .axil_req(req),
    .axil_rsp(rsp), .rxd_raw, .lf_tick, .presc_tick, .lin_hw_mode(hw), .core_domain_hibernate_keep(keep),
    .bus_pullup_on, .bus_receive_enable, .tx_testpoint_route, .tx_slew_select, .tx_duty_adjust,
    .tx_pulldown_bias, .rx_delay_select, .rx_filtered, .dominant_stuck_flag, .bus_wakeup, .bus_idle,
    .cfg_access_enabled);
  // Compare and count
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // Closing report
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // A wait ran out: count it and close
  task automatic tmo(input string n);
    chk(n, 32'h1, 32'h0);
    results();
  endtask : tmo
  // One bus access; each channel held until the edge that takes it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, fin;
    @(posedge aclk);
    req <= '{w, 32'h50015000 + {24'h0, a}, w, d, 4'hF, w, !w, 32'h50015000 + {24'h0, a}, !w};
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta  = req.awvalid & rsp.awready;
      tw  = req.wvalid & rsp.wready;
      tr  = req.arvalid & rsp.arready;
      fin = w ? req.bready & rsp.bvalid : req.rready & rsp.rvalid;
      q   = rsp.rdata;
      rs  = w ? rsp.bresp : rsp.rresp;
      @(posedge aclk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.arvalid <= 1'b0;
      if (fin) begin
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        return;
      end
    end
    tmo("bus wait");
  endtask : xfer
  // Table, then line, lock and warm reset cases
  initial begin
    int k;
    repeat (20) @(posedge aclk);
    por_n   <= 1'b1;
    aresetn <= 1'b1;
    foreach (ROWS[i]) begin
      xfer(ROWS[i].w, ROWS[i].a, ROWS[i].v);
      chk($sformatf("resp %h", ROWS[i].a), {30'h0, rs}, {30'h0, ROWS[i].r});
      if (!ROWS[i].w) chk($sformatf("data %h", ROWS[i].a), q, ROWS[i].v);
    end
    @(negedge aclk);
    chk("route", {28'h0, tx_testpoint_route}, 32'h0);
    chk("tx", {20'h0, tx_slew_select, tx_duty_adjust, tx_pulldown_bias, rx_delay_select}, 32'hFFF);
    chk("enables", {29'h0, bus_receive_enable, cfg_access_enabled, bus_pullup_on}, 32'h7);
    xfer(1'b1, 8'h10, 32'h02000043);
    @(negedge aclk);
    chk("route", {28'h0, tx_testpoint_route}, 32'h2);
    @(posedge aclk);
    dominant <= 1'b1;
    @(posedge aclk);
    dominant <= 1'b0;
    repeat (16) @(posedge aclk);
    chk("glitch", {31'h0, rx_filtered}, 32'h1);
    dominant <= 1'b1;
    for (k = 0; k < 300 && dominant_stuck_flag !== 1'b1; k++) @(posedge aclk);
    if (k == 300) tmo("flag wait");
    @(negedge aclk);
    chk("cutoff", {31'h0, bus_pullup_on}, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("flag", q, 32'hFFC);
    dominant <= 1'b0;
    for (k = 0; k < 100 && dominant_stuck_flag !== 1'b0; k++) @(posedge aclk);
    if (k == 100) tmo("release wait");
    repeat (2) @(posedge aclk);
    chk("release", {28'h0, bus_idle, wup_n == 1, bus_pullup_on, rx_filtered}, 32'h7);
    xfer(1'b1, 8'h10, 32'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0);
    chk("scratch", q, 32'hFF);
    xfer(1'b0, 8'h04, 32'h0);
    chk("lock", q, 32'h8000001B);
    xfer(1'b0, 8'h10, 32'h0);
    chk("pins", q, 32'h4B001);
    hw       <= 1'b0;
    dominant <= 1'b1;
    repeat (80) @(posedge aclk);
    chk("hw mode", {31'h0, dominant_stuck_flag}, 32'h0);
    dominant <= 1'b0;
    hw       <= 1'b1;
    keep     <= 1'b0;
    repeat (8) @(posedge aclk);
    xfer(1'b1, 8'h0C, 32'h0);
    repeat (2) begin
      @(posedge aclk);
      dominant <= 1'b1;
      repeat (32) @(posedge aclk);
      dominant <= 1'b0;
      repeat (16) @(posedge aclk);
      xfer(1'b1, 8'h14, 32'h1);
    end
    chk("width wake", wup_n, 32'h2);
    results();
  end
endmodule : aon_lin_wakeup_config_tb
`default_nettype wire
